// *** shared/pvc_pkg.sv ***
package pvc_pkg;

    // ==========================================
    // Register map and field layout
    localparam logic [4:0] ADDR_VENDOR = 5'h10;
    localparam logic [4:0] ADDR_EVENT = 5'h11;
    localparam logic [15:0] RST_VENDOR = 16'h0140;
    localparam logic [15:0] RST_EVENT = 16'h0000;
    localparam int BIT_AUTO_POLARITY_DISABLE_DIS = 5;
    localparam int BIT_RX_POL = 4;
    localparam int BIT_PCS_BYP = 1;
    localparam int BIT_RXC_SAVE = 0;
    // Writable bits of the vendor register (bits 3:2 reserved, 15:6 constant)
    localparam logic [15:0] VENDOR_WMASK = 16'h0033;
    // Event bit order, low byte; enables sit eight bits higher
    localparam int EV_NEG_DONE = 0;
    localparam int EV_REMOTE_FAULT = 1;
    localparam int EV_LINK_CHANGE = 2;
    localparam int EV_PARTNER_ACK = 3;
    localparam int EV_PAR_DET_FAULT = 4;
    localparam int EV_PAGE_RX = 5;
    localparam int EV_RX_ERROR = 6;
    localparam int EV_JABBER = 7;
    localparam int NUM_EVENTS = 8;
    localparam int ENABLE_SHIFT = 8;
    // Read data returns the cycle after the read strobe
    localparam int READ_LATENCY = 1;

endpackage

// *** shared/pvc_mgmt_if.sv ***
`timescale 1ns/10ps
// Management access between MAC controller and PHY register bank
interface pvc_mgmt_if;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic rvalid;
    logic irq;

    modport phy (
        input addr,
        input wdata,
        input wr,
        input rd,
        output rdata,
        output rvalid,
        output irq
    );
    modport mac (
        output addr,
        output wdata,
        output wr,
        output rd,
        input rdata,
        input rvalid,
        input irq
    );
endinterface

// *** core/pvc_event_flags.sv ***
`timescale 1ns/10ps
// Sticky event flags, cleared by a read, masked onto the interrupt
module pvc_event_flags #(
    parameter int NUM = 8
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [NUM-1:0] events,
    input wire logic clear,
    input wire logic [NUM-1:0] enables,
    output logic [NUM-1:0] flags,
    output logic irq
);
    typedef struct packed {
        logic [NUM-1:0] flags;
    } pvc_flag_s;

    pvc_flag_s st;
    pvc_flag_s next_st;

    initial begin
        if (NUM < 1 || NUM > 16) $error("pvc_event_flags: NUM out of range");
    end

    // ==========================================
    // Per-flag set and clear
    generate
        for (genvar i = 0; i < NUM; i++) begin : g_flag
            // Event wins over a same-cycle clearing read
            always_comb begin
                next_st.flags[i] = events[i] | (st.flags[i] & ~clear);
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign flags = st.flags;
    // Masked OR, held until the enabled flags clear
    assign irq = |(st.flags & enables);
endmodule

// *** core/pvc_phy_regs.sv ***
`timescale 1ns/10ps
module pvc_phy_regs (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    pvc_mgmt_if.phy mgmt,
    input wire logic speed_100,
    input wire logic loopback_select,
    input wire logic polarity_reversed,
    input wire logic rx_activity,
    input wire logic [7:0] events,
    output logic polarity_invert,
    output logic coding_sublayer_bypass,
    output logic rx_clock_gate_en,
    output logic rx_clock_run
);
    typedef struct packed {
        logic [15:0] vendor;
        logic [7:0] enables;
        logic [15:0] rdata;
        logic rvalid;
        logic pol_inv;
        logic bypass;
        logic clk_run;
    } pvc_regs_s;

    pvc_regs_s st;
    pvc_regs_s next_st;
    logic [7:0] flags;
    logic read_event;
    logic auto_pol_dis;
    logic save_mode;
    logic [15:0] wmask;

    // ==========================================
    // Event flags and interrupt
    assign read_event = mgmt.rd && mgmt.addr == pvc_pkg::ADDR_EVENT;

    pvc_event_flags #(
        .NUM(pvc_pkg::NUM_EVENTS)
    ) u_flags (
        .clock(clock),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .events(events),
        .clear(read_event),
        .enables(st.enables),
        .flags(flags),
        .irq(mgmt.irq)
    );

    // ==========================================
    // Register and mode logic
    assign auto_pol_dis = st.vendor[pvc_pkg::BIT_AUTO_POLARITY_DISABLE_DIS];
    // Clock saving only at 100 Mb/s and never in loopback
    assign save_mode = st.vendor[pvc_pkg::BIT_RXC_SAVE] && speed_100
        && !loopback_select;

    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        // Polarity bit writable only while auto correction is off
        wmask = pvc_pkg::VENDOR_WMASK;
        if (!auto_pol_dis) begin
            wmask[pvc_pkg::BIT_RX_POL] = 1'b0;
        end
        if (clk_en && mgmt.wr && mgmt.addr == pvc_pkg::ADDR_VENDOR) begin
            next_st.vendor = (st.vendor & ~wmask) | (mgmt.wdata & wmask);
        end
        if (clk_en && mgmt.wr && mgmt.addr == pvc_pkg::ADDR_EVENT) begin
            next_st.enables = mgmt.wdata[15:8];
        end
        // Report correction state while auto correction is on
        if (!auto_pol_dis) begin
            next_st.vendor[pvc_pkg::BIT_RX_POL] = speed_100 ? 1'b0 : polarity_reversed;
        end
        next_st.pol_inv = next_st.vendor[pvc_pkg::BIT_RX_POL];
        next_st.bypass = st.vendor[pvc_pkg::BIT_PCS_BYP] && speed_100;
        // Receive clock stops while idle in save mode
        next_st.clk_run = !save_mode || rx_activity;
        if (mgmt.rd) begin
            next_st.rvalid = 1'b1;
            unique case (mgmt.addr)
                pvc_pkg::ADDR_VENDOR: next_st.rdata = st.vendor;
                pvc_pkg::ADDR_EVENT: next_st.rdata = {st.enables, flags};
                default: next_st.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st.vendor <= pvc_pkg::RST_VENDOR;
            st.enables <= pvc_pkg::RST_EVENT[15:8];
            st.rdata <= 16'h0000;
            st.rvalid <= 1'b0;
            st.pol_inv <= 1'b0;
            st.bypass <= 1'b0;
            st.clk_run <= 1'b1;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign mgmt.rdata = st.rdata;
    assign mgmt.rvalid = st.rvalid;
    assign polarity_invert = st.pol_inv;
    assign coding_sublayer_bypass = st.bypass;
    assign rx_clock_gate_en = save_mode;
    assign rx_clock_run = st.clk_run;
endmodule

// *** core/pvc_mac_ctrl.sv ***
`timescale 1ns/10ps
// MAC-side management controller: one access at a time
module pvc_mac_ctrl (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    pvc_mgmt_if.mac mgmt,
    input wire logic req,
    input wire logic req_write,
    input wire logic [4:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic busy,
    output logic [15:0] resp_data,
    output logic resp_valid,
    output logic mac_raw_interrupt_status
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT
    } pvc_state_e;

    typedef struct packed {
        pvc_state_e state;
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
        logic [15:0] resp;
        logic resp_v;
    } pvc_mac_s;

    pvc_mac_s st;
    pvc_mac_s next_st;

    // ==========================================
    // Access sequencing
    always_comb begin
        next_st = st;
        next_st.wr = 1'b0;
        next_st.rd = 1'b0;
        next_st.resp_v = 1'b0;
        unique case (st.state)
            ST_IDLE: begin
                if (req) begin
                    next_st.addr = req_addr;
                    // Software keeps reserved bits on read-modify-write
                    next_st.wdata = req_wdata;
                    next_st.wr = req_write;
                    next_st.rd = !req_write;
                    next_st.state = req_write ? ST_IDLE : ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Read returns the addressed register; flags and enables only for the event address
                if (mgmt.rvalid) begin
                    next_st.resp = mgmt.rdata;
                    next_st.resp_v = 1'b1;
                    next_st.state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st <= '{ST_IDLE, 5'h00, 16'h0000, 1'b0, 1'b0, 16'h0000, 1'b0};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign mgmt.addr = st.addr;
    assign mgmt.wdata = st.wdata;
    assign mgmt.wr = st.wr;
    assign mgmt.rd = st.rd;
    assign busy = st.state != ST_IDLE || st.wr || st.rd;
    assign resp_data = st.resp;
    assign resp_valid = st.resp_v;
    assign mac_raw_interrupt_status = mgmt.irq;
endmodule

// *** bench/pvc_checker.sv ***
`timescale 1ns/10ps
// ========
// Watch on the management wires
module pvc_checker (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [4:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic irq
);
    logic [7:0] en_seen;
    logic rd_ev;
    logic wr_ev;
    logic rd_ven;
    logic rd_unm;
    // Decoded accesses
    assign rd_ev = rd && addr == pvc_pkg::ADDR_EVENT;
    assign wr_ev = wr && addr == pvc_pkg::ADDR_EVENT;
    assign rd_ven = rd && addr == pvc_pkg::ADDR_VENDOR;
    assign rd_unm = rd && !rd_ven && !rd_ev;
    // Shadow of the enable byte
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            en_seen <= 8'h00;
        end else if (wr_ev) begin
            en_seen <= wdata[15:8];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    a_read_answer: assert property (rd |=> rvalid)
        else $error("read not answered");
    a_answer_cause: assert property (rvalid |-> $past(rd))
        else $error("answer without read");
    a_rdata_holds: assert property (!rvalid |-> $stable(rdata))
        else $error("read data moved");
    a_vendor_fixed: assert property (rd_ven |=> (rdata & 16'hffcc) == 16'h0140)
        else $error("vendor fixed bits wrong");
    a_unmapped_zero: assert property (rd_unm |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_enable_readback: assert property (rd_ev |=> rdata[15:8] == en_seen)
        else $error("enable byte wrong");
    a_irq_needs_en: assert property (en_seen == 8'h00 |-> !irq)
        else $error("interrupt without enable");
    a_irq_fall_cause: assert property ($fell(irq) |-> $past(rd_ev) || $past(wr_ev))
        else $error("interrupt dropped alone");
    // Main traffic seen
    c_irq: cover property ($rose(irq));
    c_ev_read: cover property (rd_ev ##1 rdata[7:0] != 8'h00);
    c_ven_write: cover property (wr && addr == pvc_pkg::ADDR_VENDOR);
endmodule

// *** bench/tb_phy_vendor_ctrl_and_irq_regs.sv ***
`timescale 1ns/10ps
module tb_phy_vendor_ctrl_and_irq_regs;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic req = 1'b0;
    logic rw = 1'b0;
    logic s100 = 1'b0;
    logic lpb = 1'b0;
    logic rev = 1'b0;
    logic act = 1'b1;
    logic [4:0] ra = 5'h00;
    logic [15:0] wd = 16'h0000;
    logic [7:0] ev = 8'h00;
    logic [15:0] q;
    logic [15:0] rsp;
    logic busy, rv, mri, pinv, byp, gate, run;
    int n_mismatch = 0;
    int num_checks = 0;
    localparam logic [4:0] VA = pvc_pkg::ADDR_VENDOR;
    localparam logic [4:0] EA = pvc_pkg::ADDR_EVENT;
    // Clock
    always #5 clock = ~clock;
    // ========
    // Both ends joined
    pvc_mgmt_if i_pvc_mgmt_if ();
    pvc_phy_regs i_pvc_phy_regs (.clock(clock), .arst_n(arst_n), .clk_en(1'b1),
        .mgmt(i_pvc_mgmt_if.phy), .speed_100(s100), .loopback_select(lpb),
        .polarity_reversed(rev), .rx_activity(act), .events(ev), .polarity_invert(pinv),
        .coding_sublayer_bypass(byp), .rx_clock_gate_en(gate), .rx_clock_run(run));
    pvc_mac_ctrl i_pvc_mac_ctrl (.clock(clock), .arst_n(arst_n), .clk_en(1'b1),
        .mgmt(i_pvc_mgmt_if.mac), .req(req), .req_write(rw), .req_addr(ra), .req_wdata(wd),
        .busy(busy), .resp_data(rsp), .resp_valid(rv), .mac_raw_interrupt_status(mri));
    pvc_checker i_pvc_checker (.clock(clock), .arst_n(arst_n), .addr(i_pvc_mgmt_if.addr),
        .wdata(i_pvc_mgmt_if.wdata), .wr(i_pvc_mgmt_if.wr), .rd(i_pvc_mgmt_if.rd),
        .rdata(i_pvc_mgmt_if.rdata), .rvalid(i_pvc_mgmt_if.rvalid), .irq(i_pvc_mgmt_if.irq));
    // ========
    // Tasks
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t word %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t bit %b not %b", $time, got, exp);
        end
    endtask
    // One access; events e ride the cycle of the strobe
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
        input logic [7:0] e);
        int n;
        n = 0;
        @(posedge clock) req <= 1'b1;
        rw <= w;
        ra <= a;
        wd <= d;
        @(posedge clock) req <= 1'b0;
        ev <= e;
        @(posedge clock) ev <= 8'h00;
        @(negedge clock);
        while ((w ? busy : !rv) !== 1'b0 && n < 8) begin
            @(negedge clock);
            n++;
        end
        if (n == 8) begin
            n_mismatch++;
            $display("[FAIL] %0t access hung", $time);
            tally_and_finish();
        end
        q = rsp;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        acc(1'b0, a, 16'h0000, 8'h00);
        chk16(q, exp);
    endtask
    task automatic pulse(input logic [7:0] e);
        @(posedge clock) ev <= e;
        @(posedge clock) ev <= 8'h00;
        @(negedge clock);
    endtask
    task automatic s_polarity;
        @(posedge clock) rev <= 1'b1;
        acc(1'b1, VA, 16'h0010, 8'h00);
        rd_chk(VA, 16'h0150);
        chk1(pinv, 1'b1);
        @(posedge clock) rev <= 1'b0;
        acc(1'b1, VA, 16'hffff, 8'h00);
        @(posedge clock) rev <= 1'b1;
        rd_chk(VA, 16'h0163);
        chk1(pinv, 1'b0);
        acc(1'b1, VA, 16'h0033, 8'h00);
        rd_chk(VA, 16'h0173);
        chk1(pinv, 1'b1);
        @(posedge clock) rev <= 1'b0;
        acc(1'b1, VA, 16'h0000, 8'h00);
        rd_chk(VA, 16'h0140);
    endtask
    task automatic s_modes;
        @(posedge clock) s100 <= 1'b1;
        acc(1'b1, VA, 16'h0001, 8'h00);
        chk1(gate, 1'b1);
        @(posedge clock) act <= 1'b0;
        repeat (2) @(negedge clock);
        chk1(run, 1'b0);
        @(posedge clock) lpb <= 1'b1;
        repeat (2) @(negedge clock);
        chk1(gate, 1'b0);
        chk1(run, 1'b1);
        // Bypass alone, clock saving off; output registered one cycle later
        acc(1'b1, VA, 16'h0002, 8'h00);
        @(negedge clock);
        chk1(byp, 1'b1);
        @(posedge clock) s100 <= 1'b0;
        repeat (2) @(negedge clock);
        chk1(byp, 1'b0);
        acc(1'b1, VA, 16'h0000, 8'h00);
    endtask
    task automatic s_events;
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i);
            chk1(mri, 1'b0);
            rd_chk(EA, {8'h00, 8'(8'h01 << i)});
        end
        rd_chk(EA, 16'h0000);
        acc(1'b1, EA, 16'hffff, 8'h00);
        rd_chk(EA, 16'hff00);
        pulse(8'h04);
        chk1(mri, 1'b1);
        rd_chk(EA, 16'hff04);
        chk1(mri, 1'b0);
        acc(1'b1, EA, 16'h0100, 8'h00);
        pulse(8'h02);
        chk1(mri, 1'b0);
        pulse(8'h01);
        chk1(mri, 1'b1);
        acc(1'b0, EA, 16'h0000, 8'h40);
        chk16(q, 16'h0103);
        rd_chk(EA, 16'h0140);
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        rd_chk(VA, pvc_pkg::RST_VENDOR);
        rd_chk(EA, pvc_pkg::RST_EVENT);
        rd_chk(5'h05, 16'h0000);
        s_polarity();
        s_modes();
        s_events();
        tally_and_finish();
    end
endmodule
